// ### bench/sdc_ctrl_model.sv
// sdc_ctrl_model.sv: memory controller model driving the command pins
// assumes: the caller waits for each task call to return before the next one
`timescale 1ns/1ps
module sdc_ctrl_model (
  input wire logic clk,
  output logic chip_sel_n,
  output logic row_strobe_n,
  output logic column_strobe_n,
  output logic write_strobe_n,
  output logic clock_gate_in,
  output logic bank_sel_0,
  output logic bank_sel_1,
  output logic autoprecharge_addr_bit,
  output logic byte_mask,
  output logic full_page
);
  // ==========================================
  // idle bus: nop with gate high
  initial begin
    {chip_sel_n, row_strobe_n, column_strobe_n, write_strobe_n} = 4'h7;
    clock_gate_in = 1'b1;
    {bank_sel_1, bank_sel_0, autoprecharge_addr_bit, byte_mask} = 4'h0;
    full_page = 1'b0;
  end
  // ==========================================
  // full page burst setting, changed between commands
  task automatic page(input logic fp);
    @(posedge clk);
    full_page <= fp;
  endtask
  // ==========================================
  // one command, then back to nop at the taking edge
  // callers keep the bank and idle order legal
  task automatic cmd(input logic cs, input logic [2:0] rcw, input logic gate, input logic [1:0] bank,
                     input logic ap, input logic msk);
    @(posedge clk);
    chip_sel_n <= cs;
    {row_strobe_n, column_strobe_n, write_strobe_n} <= rcw;
    clock_gate_in <= gate;
    {bank_sel_1, bank_sel_0} <= bank;
    autoprecharge_addr_bit <= ap;
    byte_mask <= msk;
    @(posedge clk);
    chip_sel_n <= 1'b0;
    {row_strobe_n, column_strobe_n, write_strobe_n} <= 3'h7;
  endtask
endmodule // sdc_ctrl_model

// ### bench/tb_sdc_core.sv
// tb_sdc_core.sv: self-checking bench for the command decoder
// assumes: sdc_ctrl_model plays the controller, banks and bursts follow its legal order
`timescale 1ns/1ps
module tb_sdc_core;
  logic clk, reset_n, chip_sel_n, row_strobe_n, column_strobe_n, write_strobe_n, clock_gate_in;
  logic bank_sel_0, bank_sel_1, autoprecharge_addr_bit, byte_mask, full_page;
  logic [3:0] bank_active;
  logic burst_busy, burst_write, internal_clk_en, suspended, power_down, self_refresh;
  logic refresh_pulse, mode_set_pulse, write_enable, data_out_en;
  int miscompares = 0, check_count = 0, n_ref = 0, n_mrs = 0, n_we = 0, n_oe = 0;
  localparam logic [2:0] ACT = 3'h3, PRE = 3'h2, WR = 3'h4, RD = 3'h5, MRS = 3'h0, REF = 3'h1, NOP = 3'h7;
  localparam logic [2:0] BST = 3'h6;
  // ==========================================
  sdc_core u_sdc_core (.clk(clk), .reset_n(reset_n), .chip_sel_n(chip_sel_n), .row_strobe_n(row_strobe_n),
    .column_strobe_n(column_strobe_n), .write_strobe_n(write_strobe_n), .clock_gate_in(clock_gate_in),
    .bank_sel_0(bank_sel_0), .bank_sel_1(bank_sel_1), .autoprecharge_addr_bit(autoprecharge_addr_bit),
    .byte_mask(byte_mask), .full_page(full_page), .bank_active(bank_active), .burst_busy(burst_busy),
    .burst_write(burst_write), .internal_clk_en(internal_clk_en), .suspended(suspended),
    .power_down(power_down), .self_refresh(self_refresh), .refresh_pulse(refresh_pulse),
    .mode_set_pulse(mode_set_pulse), .write_enable(write_enable), .data_out_en(data_out_en));
  sdc_ctrl_model u_sdc_ctrl_model (.clk(clk), .chip_sel_n(chip_sel_n), .row_strobe_n(row_strobe_n),
    .column_strobe_n(column_strobe_n), .write_strobe_n(write_strobe_n), .clock_gate_in(clock_gate_in),
    .bank_sel_0(bank_sel_0), .bank_sel_1(bank_sel_1), .autoprecharge_addr_bit(autoprecharge_addr_bit),
    .byte_mask(byte_mask), .full_page(full_page));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // pulse counters, cleared by the tests
  always @(posedge clk) begin
    n_ref += refresh_pulse;
    n_mrs += mode_set_pulse;
    n_we += write_enable;
    n_oe += data_out_en;
  end
  // ==========================================
  task chk(input string nm, input logic [3:0] exp, input logic [3:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ==========================================
  task t_burst;
    u_sdc_ctrl_model.cmd(1'b0, ACT, 1'b1, 2'h0, 1'b0, 1'b0);
    #1 chk("bank_active", 4'h1, bank_active);
    n_oe = 0;
    u_sdc_ctrl_model.cmd(1'b0, RD, 1'b1, 2'h0, 1'b0, 1'b0);
    step(12);
    chk("read beats", 4'h8, n_oe[3:0]);
    chk("burst_busy", 4'h0, {3'h0, burst_busy});
    chk("burst_write", 4'h0, {3'h0, burst_write});
    n_we = 0;
    u_sdc_ctrl_model.cmd(1'b0, WR, 1'b1, 2'h0, 1'b0, 1'b1);
    step(12);
    chk("masked beats", 4'h0, n_we[3:0]);
    chk("burst_write", 4'h1, {3'h0, burst_write});
    n_we = 0;
    u_sdc_ctrl_model.cmd(1'b0, WR, 1'b1, 2'h0, 1'b1, 1'b0);
    step(12);
    chk("write beats", 4'h8, n_we[3:0]);
    chk("bank_active", 4'h0, bank_active);
    $display("test burst done");
  endtask
  task t_desel;
    n_mrs = 0;
    n_ref = 0;
    u_sdc_ctrl_model.cmd(1'b1, MRS, 1'b1, 2'h0, 1'b0, 1'b0);
    u_sdc_ctrl_model.cmd(1'b1, REF, 1'b1, 2'h0, 1'b0, 1'b0);
    step(3);
    chk("deselect pulses", 4'h0, n_mrs[3:0] + n_ref[3:0]);
    u_sdc_ctrl_model.cmd(1'b0, MRS, 1'b1, 2'h0, 1'b0, 1'b0);
    u_sdc_ctrl_model.cmd(1'b0, REF, 1'b1, 2'h0, 1'b0, 1'b0);
    step(3);
    chk("mode_set count", 4'h1, n_mrs[3:0]);
    chk("refresh count", 4'h1, n_ref[3:0]);
    $display("test deselect done");
  endtask
  // burst running when the gate drops: the registering edge still beats
  task t_susp;
    n_oe = 0;
    u_sdc_ctrl_model.cmd(1'b0, ACT, 1'b1, 2'h1, 1'b0, 1'b0);
    u_sdc_ctrl_model.cmd(1'b0, RD, 1'b1, 2'h1, 1'b0, 1'b0);
    u_sdc_ctrl_model.cmd(1'b0, NOP, 1'b0, 2'h0, 1'b0, 1'b0);
    #1 chk("clk_en after gate low", 4'h0, {3'h0, internal_clk_en});
    step(1);
    chk("beats up to gate edge", 4'h2, n_oe[3:0]);
    chk("suspended", 4'h1, {3'h0, suspended});
    u_sdc_ctrl_model.cmd(1'b0, PRE, 1'b0, 2'h1, 1'b0, 1'b0);
    step(1);
    chk("bank_active held", 4'h2, bank_active);
    chk("beats frozen", 4'h2, n_oe[3:0]);
    chk("burst held", 4'h1, {3'h0, burst_busy});
    u_sdc_ctrl_model.cmd(1'b0, NOP, 1'b1, 2'h0, 1'b0, 1'b0);
    step(1);
    chk("clk_en resumed", 4'h1, {3'h0, internal_clk_en});
    chk("suspended", 4'h0, {3'h0, suspended});
    step(8);
    chk("beats after resume", 4'h8, n_oe[3:0]);
    u_sdc_ctrl_model.cmd(1'b0, PRE, 1'b1, 2'h0, 1'b1, 1'b0);
    #1 chk("precharge all", 4'h0, bank_active);
    $display("test suspend done");
  endtask
  task t_pdown;
    u_sdc_ctrl_model.cmd(1'b0, NOP, 1'b0, 2'h0, 1'b0, 1'b0);
    step(1);
    chk("power_down", 4'h1, {3'h0, power_down});
    u_sdc_ctrl_model.cmd(1'b0, ACT, 1'b0, 2'h2, 1'b0, 1'b0);
    u_sdc_ctrl_model.cmd(1'b0, NOP, 1'b1, 2'h0, 1'b0, 1'b0);
    step(1);
    chk("power_down", 4'h0, {3'h0, power_down});
    chk("bank_active", 4'h0, bank_active);
    $display("test power down done");
  endtask
  task t_sref;
    u_sdc_ctrl_model.cmd(1'b0, REF, 1'b0, 2'h0, 1'b0, 1'b0);
    step(1);
    chk("self_refresh", 4'h1, {3'h0, self_refresh});
    n_mrs = 0;
    u_sdc_ctrl_model.cmd(1'b0, MRS, 1'b0, 2'h0, 1'b0, 1'b0);
    step(2);
    chk("mode_set in sref", 4'h0, n_mrs[3:0]);
    u_sdc_ctrl_model.cmd(1'b1, NOP, 1'b1, 2'h0, 1'b0, 1'b0);
    step(1);
    chk("self_refresh", 4'h0, {3'h0, self_refresh});
    $display("test self refresh done");
  endtask
  // full page read cut by burst stop, bank stays open
  task t_bstop;
    u_sdc_ctrl_model.page(1'b1);
    u_sdc_ctrl_model.cmd(1'b0, ACT, 1'b1, 2'h3, 1'b0, 1'b0);
    u_sdc_ctrl_model.cmd(1'b0, RD, 1'b1, 2'h3, 1'b0, 1'b0);
    u_sdc_ctrl_model.cmd(1'b0, BST, 1'b1, 2'h3, 1'b0, 1'b0);
    step(2);
    chk("burst stopped", 4'h0, {3'h0, burst_busy});
    chk("bank kept open", 4'h8, bank_active);
    n_ref = 0;
    u_sdc_ctrl_model.cmd(1'b0, REF, 1'b1, 2'h0, 1'b0, 1'b0);
    u_sdc_ctrl_model.cmd(1'b0, PRE, 1'b1, 2'h3, 1'b0, 1'b0);
    #1 chk("bank_active", 4'h0, bank_active);
    chk("refresh refused", 4'h0, n_ref[3:0]);
    u_sdc_ctrl_model.page(1'b0);
    $display("test burst stop done");
  endtask
  // ==========================================
  initial begin
    reset_n = 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    t_burst;
    t_desel;
    t_susp;
    t_pdown;
    t_sref;
    t_bstop;
    stop_test;
  end
  initial begin
    #400000;
    miscompares++;
    $display("[ERR] watchdog expected finish seen hang");
    stop_test;
  end
endmodule // tb_sdc_core

// ### rtl/sdc_cfg.svh
// sdc_cfg.svh: constants for the sdram command decoder
// assumes: included by bare name from the core rtl file only
// How it works
// [RQ1] decode only on rising clock edge
// [RQ2] cs low, strobes high is no-operation
// [RQ3] no-operation never cuts a running burst
// [RQ4] controller idles the bus with no-operation
// [RQ5] cs high is deselect, same as nop
// [RQ6] controller keeps clock gate high normally
// [RQ7] gate low with active bank suspends
// [RQ8] suspension starts one cycle after registering
// [RQ9] suspended device ignores every command
// [RQ10] suspend ends one cycle after gate high
// [RQ11] normal commands need previous gate high
// [RQ12] strobe patterns decode to the commands
// [RQ13] current gate level splits refresh and suspend; code splits auto refresh from self refresh
// [RQ14] controller obeys bank and idle preconditions
// [RQ15] burst stop only for full page
// [RQ16] power-down during burst becomes clock suspend
// [RQ17] prev low, now high, nop exits
// [RQ18] byte mask high blocks writes and outputs
// [RQ19] power-down gates all inputs but gate
// [RQ20] self-refresh holds while gate stays low
// [RQ21] illegal-state command leaves state unchanged
`ifndef SDC_CFG_SVH
`define SDC_CFG_SVH
`define SDC_BANKS 4
`define SDC_BANK_W 2
`define SDC_BURST_W 4
`define SDC_BURST_LEN 4'h8
`endif

// ### rtl/sdc_core.sv
// sdc_core.sv: command decode, bank state and clock gating of the memory
// assumes: controller logic drives all inputs synchronous to clk
`timescale 1ns/1ps
`include "sdc_cfg.svh"
module sdc_core #(
  parameter int BANKS = `SDC_BANKS,
  parameter logic [`SDC_BURST_W-1:0] BURST_LEN = `SDC_BURST_LEN
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic chip_sel_n,
  input wire logic row_strobe_n,
  input wire logic column_strobe_n,
  input wire logic write_strobe_n,
  input wire logic clock_gate_in,
  input wire logic bank_sel_0,
  input wire logic bank_sel_1,
  input wire logic autoprecharge_addr_bit,
  input wire logic byte_mask,
  input wire logic full_page,
  output logic [BANKS-1:0] bank_active,
  output logic burst_busy,
  output logic burst_write,
  output logic internal_clk_en,
  output logic suspended,
  output logic power_down,
  output logic self_refresh,
  output logic refresh_pulse,
  output logic mode_set_pulse,
  output logic write_enable,
  output logic data_out_en
);
  // ==========================================================
  // state
  typedef struct packed {
    logic gate_level_prev;
    logic [BANKS-1:0] bank_active;
    logic [`SDC_BURST_W-1:0] burst_left;
    logic burst_write;
    logic burst_ap;
    logic [1:0] burst_bank;
    sdc_pkg::sdc_mode_e mode;
    logic clk_en;
    logic refresh_pulse;
    logic mode_set_pulse;
    logic write_enable;
    logic data_out_en;
  } sdc_state_s;

  sdc_state_s st;
  sdc_state_s next_st;
  sdc_pkg::sdc_cmd_e cmd;
  logic [1:0] bank_idx;
  logic any_active;
  logic in_burst;
  logic gate_level_now;

  assign gate_level_now = clock_gate_in;
  assign bank_idx = {bank_sel_1, bank_sel_0};
  assign any_active = |st.bank_active;
  assign in_burst = st.burst_left != '0;

  sdc_decode u_decode (
    .chip_sel_n(chip_sel_n),
    .row_strobe_n(row_strobe_n),
    .column_strobe_n(column_strobe_n),
    .write_strobe_n(write_strobe_n),
    .gate_level_now(gate_level_now),
    .cmd(cmd)
  );

  // ==========================================================
  // next state
  always_comb begin
    next_st = st;
    next_st.gate_level_prev = gate_level_now; // see [RQ11]
    next_st.refresh_pulse = 1'b0;
    next_st.mode_set_pulse = 1'b0;
    next_st.write_enable = 1'b0;
    next_st.data_out_en = 1'b0;
    case (st.mode)
      sdc_pkg::sdc_mode_normal: begin
        // burst advances only while clock is enabled
        if (st.clk_en && in_burst) begin // see [RQ3]
          next_st.burst_left = st.burst_left - 1'b1;
          next_st.write_enable = st.burst_write && !byte_mask; // see [RQ18]
          next_st.data_out_en = !st.burst_write && !byte_mask; // see [RQ18]
          if (st.burst_left == 1 && st.burst_ap) begin
            next_st.bank_active[st.burst_bank] = 1'b0;
          end
        end
        if (!st.clk_en) begin
          next_st.clk_en = 1'b1; // see [RQ10]
        end else if (st.gate_level_prev && !gate_level_now && cmd != sdc_pkg::sdc_cmd_sref) begin
          // suspend or power-down, effective next cycle
          if (any_active || in_burst) begin // see [RQ7] see [RQ16]
            next_st.mode = sdc_pkg::sdc_mode_suspend;
          end else begin
            next_st.mode = sdc_pkg::sdc_mode_pdown; // see [RQ19]
          end
          next_st.clk_en = 1'b0; // see [RQ8]
        end else if (st.gate_level_prev) begin // see [RQ11]
          case (cmd)
            sdc_pkg::sdc_cmd_act: begin
              if (!st.bank_active[bank_idx] && !in_burst) next_st.bank_active[bank_idx] = 1'b1; // see [RQ21]
            end
            sdc_pkg::sdc_cmd_pre: begin
              if (!(in_burst && st.burst_ap)) begin // see [RQ21]
                if (autoprecharge_addr_bit) next_st.bank_active = '0; // see [RQ12]
                else next_st.bank_active[bank_idx] = 1'b0;
                if (autoprecharge_addr_bit || bank_idx == st.burst_bank) next_st.burst_left = '0;
              end
            end
            sdc_pkg::sdc_cmd_rd, sdc_pkg::sdc_cmd_wr: begin
              if (st.bank_active[bank_idx] && !(in_burst && st.burst_ap)) begin // see [RQ21]
                next_st.burst_left = BURST_LEN;
                next_st.burst_write = cmd == sdc_pkg::sdc_cmd_wr;
                next_st.burst_ap = autoprecharge_addr_bit && !full_page;
                next_st.burst_bank = bank_idx;
              end
            end
            sdc_pkg::sdc_cmd_bst: begin
              if (full_page) next_st.burst_left = '0;
            end
            sdc_pkg::sdc_cmd_mrs: begin
              if (!any_active) next_st.mode_set_pulse = 1'b1;
            end
            sdc_pkg::sdc_cmd_ref: begin
              if (!any_active) next_st.refresh_pulse = 1'b1;
            end
            sdc_pkg::sdc_cmd_sref: begin
              if (!any_active && !in_burst) begin // see [RQ13]
                next_st.mode = sdc_pkg::sdc_mode_sref;
                next_st.clk_en = 1'b0;
              end
            end
            default: begin
            end
          endcase
        end
      end
      sdc_pkg::sdc_mode_suspend: begin
        // every command ignored while frozen
        if (gate_level_now) begin // see [RQ9] see [RQ10]
          next_st.mode = sdc_pkg::sdc_mode_normal;
        end
      end
      sdc_pkg::sdc_mode_pdown, sdc_pkg::sdc_mode_sref: begin
        if (!st.gate_level_prev && gate_level_now && cmd == sdc_pkg::sdc_cmd_nop) begin // see [RQ17] see [RQ20]
          next_st.mode = sdc_pkg::sdc_mode_normal;
        end
      end
      default: next_st.mode = sdc_pkg::sdc_mode_normal;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st <= '{mode: sdc_pkg::sdc_mode_normal, clk_en: 1'b1, default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign bank_active = st.bank_active;
  assign burst_busy = in_burst;
  assign burst_write = st.burst_write;
  assign internal_clk_en = st.clk_en;
  assign suspended = st.mode == sdc_pkg::sdc_mode_suspend;
  assign power_down = st.mode == sdc_pkg::sdc_mode_pdown;
  assign self_refresh = st.mode == sdc_pkg::sdc_mode_sref;
  assign refresh_pulse = st.refresh_pulse;
  assign mode_set_pulse = st.mode_set_pulse;
  assign write_enable = st.write_enable;
  assign data_out_en = st.data_out_en;

  // ==========================================================
  // checks
  suspend_entry_a: assert property (@(posedge clk) disable iff (!reset_n) // see [RQ8]
    st.mode == sdc_pkg::sdc_mode_normal && st.clk_en && st.gate_level_prev && !clock_gate_in
      && any_active && cmd != sdc_pkg::sdc_cmd_sref |=> suspended && !internal_clk_en)
    else $error("suspend not entered one cycle after gate low");
  suspend_freeze_a: assert property (@(posedge clk) disable iff (!reset_n) // see [RQ9]
    suspended |=> $stable(bank_active))
    else $error("banks changed during suspend");
  suspend_exit_a: assert property (@(posedge clk) disable iff (!reset_n) // see [RQ10]
    suspended && clock_gate_in |=> !suspended ##1 internal_clk_en)
    else $error("suspend exit timing wrong");
  nop_keeps_burst_a: assert property (@(posedge clk) disable iff (!reset_n) // see [RQ3]
    st.mode == sdc_pkg::sdc_mode_normal && st.clk_en && burst_busy && st.burst_left > 1
      && cmd == sdc_pkg::sdc_cmd_nop && clock_gate_in |=> burst_busy)
    else $error("nop cut a burst");
  activate_bank_a: assert property (@(posedge clk) disable iff (!reset_n) // see [RQ12]
    st.mode == sdc_pkg::sdc_mode_normal && st.clk_en && st.gate_level_prev && clock_gate_in
      && cmd == sdc_pkg::sdc_cmd_act && !burst_busy |=> bank_active[$past(bank_idx)])
    else $error("activate did not open bank");
  prev_gate_a: assert property (@(posedge clk) disable iff (!reset_n) // see [RQ11]
    st.mode == sdc_pkg::sdc_mode_normal && st.clk_en && !st.gate_level_prev |=> !refresh_pulse && !mode_set_pulse)
    else $error("command taken with previous gate low");
  pdown_burst_a: assert property (@(posedge clk) disable iff (!reset_n) // see [RQ16]
    power_down |-> !burst_busy)
    else $error("power down during burst");
  sref_hold_a: assert property (@(posedge clk) disable iff (!reset_n) // see [RQ20]
    self_refresh && !clock_gate_in |=> self_refresh)
    else $error("self refresh left while gate low");
  mask_output_a: assert property (@(posedge clk) disable iff (!reset_n) // see [RQ18]
    byte_mask |=> !write_enable && !data_out_en)
    else $error("byte mask did not block data");
  deselect_idle_a: assert property (@(posedge clk) disable iff (!reset_n) // see [RQ5]
    st.mode == sdc_pkg::sdc_mode_normal && chip_sel_n && !burst_busy
      |=> $stable(bank_active) && !refresh_pulse && !mode_set_pulse)
    else $error("deselect changed state");
  pdown_exit_a: assert property (@(posedge clk) disable iff (!reset_n) // see [RQ17]
    power_down && !st.gate_level_prev && clock_gate_in && chip_sel_n |=> !power_down)
    else $error("power down not left on gate rise");
  pdown_hold_a: assert property (@(posedge clk) disable iff (!reset_n) // see [RQ19]
    power_down |=> $stable(bank_active) && !refresh_pulse && !mode_set_pulse)
    else $error("input taken during power down");
  sref_entry_a: assert property (@(posedge clk) disable iff (!reset_n) // see [RQ13]
    st.mode == sdc_pkg::sdc_mode_normal && st.clk_en && st.gate_level_prev && !clock_gate_in
      && cmd == sdc_pkg::sdc_cmd_sref && !any_active && !burst_busy |=> self_refresh)
    else $error("self refresh not entered");
  auto_refresh_a: assert property (@(posedge clk) disable iff (!reset_n) // see [RQ12]
    st.mode == sdc_pkg::sdc_mode_normal && st.clk_en && st.gate_level_prev && clock_gate_in
      && cmd == sdc_pkg::sdc_cmd_ref && !any_active |=> refresh_pulse)
    else $error("auto refresh not issued");
endmodule // sdc_core

// ### rtl/sdc_decode.sv
// sdc_decode.sv: combinational strobe pattern decoder
// assumes: inputs already sampled on clk
`timescale 1ns/1ps
module sdc_decode (
  input wire logic chip_sel_n,
  input wire logic row_strobe_n,
  input wire logic column_strobe_n,
  input wire logic write_strobe_n,
  input wire logic gate_level_now,
  output sdc_pkg::sdc_cmd_e cmd
);
  always_comb begin
    cmd = sdc_pkg::sdc_cmd_nop;
    if (!chip_sel_n) begin // see [RQ5]
      case ({row_strobe_n, column_strobe_n, write_strobe_n}) // see [RQ12]
        3'h3: cmd = sdc_pkg::sdc_cmd_act;
        3'h2: cmd = sdc_pkg::sdc_cmd_pre;
        3'h4: cmd = sdc_pkg::sdc_cmd_wr;
        3'h5: cmd = sdc_pkg::sdc_cmd_rd;
        3'h0: cmd = sdc_pkg::sdc_cmd_mrs;
        3'h6: cmd = sdc_pkg::sdc_cmd_bst;
        3'h1: cmd = gate_level_now ? sdc_pkg::sdc_cmd_ref : sdc_pkg::sdc_cmd_sref; // see [RQ13]
        default: cmd = sdc_pkg::sdc_cmd_nop; // see [RQ2]
      endcase
    end
  end
endmodule // sdc_decode

// ### rtl/sdc_pkg.sv
// sdc_pkg.sv: types for the sdram command decoder
// assumes: nothing
package sdc_pkg;
  typedef enum logic [3:0] {
    sdc_cmd_nop, sdc_cmd_act, sdc_cmd_pre, sdc_cmd_wr, sdc_cmd_rd, sdc_cmd_mrs,
    sdc_cmd_bst, sdc_cmd_ref, sdc_cmd_sref
  } sdc_cmd_e;
  typedef enum logic [2:0] {
    sdc_mode_normal, sdc_mode_suspend, sdc_mode_pdown, sdc_mode_sref
  } sdc_mode_e;
endpackage
